// *** ptc_assertions.sv ***
// ptc_assertions.sv: port checks of the threshold bank.
// assumes: bound to the bank top; one clock, async reset.
`timescale 1ns/1ps
module ptc_assertions (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [7:0] reg_addr, // offset
	input wire logic [7:0] reg_rdata_q, // data
	input wire logic reg_rvalid_q, // valid
	input wire logic wr_refused_q, // refused
	input wire logic pwm_run, // run bit
	input wire logic ev_temp_near, // event
	input wire logic ev_out_of_window, // event
	input wire logic ev_overcurrent, // event
	input wire logic ev_overvoltage, // event
	input wire logic ev_overtemp, // event
	input wire logic ev_track_fail, // event
	input wire logic ev_undervoltage, // event
	input wire logic warning_q, // class
	input wire logic fault_q, // class
	input wire logic error_q, // class
	input wire logic [2:0] load_line_gain_q, // gain
	input wire logic [8:0] load_line_centi_q // gain
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// register port timing and lock
	a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
		else $error("read not answered");
	a_read_cause: assert property (reg_rvalid_q |-> $past(reg_rd))
		else $error("read answer without read");
	a_refuse_locked: assert property
		(reg_wr && reg_addr == 8'h09 && pwm_run |=> wr_refused_q)
		else $error("locked write not refused");
	a_refuse_cause: assert property
		(wr_refused_q |-> $past(reg_wr && reg_addr == 8'h09 && pwm_run))
		else $error("refusal without cause");
	a_top_bits_zero: assert property
		(reg_rvalid_q && $past(reg_addr) == 8'h09 |-> reg_rdata_q[7:6] == 2'h0)
		else $error("unused bits read nonzero");
	// event classes one cycle after the events; gain code zero exactly when gain value zero
	a_warn_class: assert property ($past(rst_n) |->
		warning_q == $past(ev_temp_near | ev_out_of_window))
		else $error("warning class wrong");
	a_fault_class: assert property ($past(rst_n) |-> fault_q ==
		$past(ev_overcurrent | ev_overvoltage | ev_overtemp | ev_track_fail))
		else $error("fault class wrong");
	a_error_class: assert property
		($past(rst_n) |-> error_q == $past(ev_undervoltage))
		else $error("error class wrong");
	a_gain_zero: assert property
		((load_line_gain_q == 3'h0) == (load_line_centi_q == 9'h000))
		else $error("gain value off");
endmodule // ptc_assertions

// *** ptc_defs.vh ***
// ptc_defs.vh: offsets, field positions, reset values and codes for the
// protection threshold configuration bank.
// assumes: included by bare name from the design files of this block.
// Notes on behaviour
// - threshold register writable only while the modulator run bit is zero
// - bit 5 picks 105% or 110% upper good limit; bit 4 95% or 90%
// - bits 3:2 pick 110/120/130/140% overvoltage; bits 1:0 75..90% undervoltage
// - absolute thresholds follow the present setpoint and rescale on change
// - limit 37% plus 10% per step, 0xB and above 140%; bit 4 temp comp
// - events sorted into warnings, faults and errors
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// register offsets
`define PTC_OFS_CURRENT_LIMIT_SETTING 8'h08
`define PTC_OFS_PROTECTION_CONFIG_TWO 8'h09

// reset values
`define PTC_RST_CURRENT_LIMIT_SETTING 8'h1b
`define PTC_RST_PROTECTION_CONFIG_TWO 8'h08

// protection_config_two fields
`define PTC_GOOD_UPPER_BIT 5
`define PTC_GOOD_LOWER_BIT 4
`define PTC_OV_MSB 3
`define PTC_OV_LSB 2
`define PTC_UV_MSB 1
`define PTC_UV_LSB 0
`define PTC_THRESH_IMPL_MASK 8'h3f

// current_limit_setting fields
`define PTC_GAIN_MSB 7
`define PTC_GAIN_LSB 5
`define PTC_TCOMP_BIT 4
`define PTC_OC_MSB 3
`define PTC_OC_LSB 0

// percentages of the setpoint
`define PTC_PCT_GOOD_UP_LOW 8'h69
`define PTC_PCT_GOOD_UP_HIGH 8'h6e
`define PTC_PCT_GOOD_LO_HIGH 8'h5f
`define PTC_PCT_GOOD_LO_LOW 8'h5a
`define PTC_PCT_OV_BASE 8'h6e
`define PTC_PCT_OV_STEP 8'h0a
`define PTC_PCT_UV_BASE 8'h4b
`define PTC_PCT_UV_STEP 8'h05
`define PTC_PCT_OC_BASE 8'h25
`define PTC_PCT_OC_STEP 8'h0a
`define PTC_OC_CODE_MAX 4'hb
`define PTC_PCT_OC_TOP 8'h8c
`define PTC_PCT_DIVISOR 8'h64

// load-line gain in hundredths of V/A/ohm, per code
`define PTC_GAIN_C0 9'h000
`define PTC_GAIN_C1 9'h027
`define PTC_GAIN_C2 9'h04e
`define PTC_GAIN_C3 9'h076
`define PTC_GAIN_C4 9'h09d
`define PTC_GAIN_C5 9'h0c4
`define PTC_GAIN_C6 9'h0eb
`define PTC_GAIN_C7 9'h113

`endif

// *** ptc_host_model.sv ***
// ptc_host_model.sv: register host programming the bank.
// assumes: strobes one cycle wide, driven at falling edge.
`timescale 1ns/1ps
module ptc_host_model (
	input wire logic ref_clk, // clock
	output logic reg_wr = 0, // write
	output logic reg_rd = 0, // read
	output logic [7:0] reg_addr = 0, // offset
	output logic [7:0] reg_wdata = 0, // data
	output logic pwm_run = 0, // run bit; low except while the bench checks the write lock
	input wire logic [7:0] reg_rdata_q, // data
	input wire logic reg_rvalid_q, // valid
	input wire logic wr_refused_q // refused
);
	// one write; released lines show inverted values
	task automatic wr(input logic [7:0] a, v, output logic r);
		@(negedge ref_clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge ref_clk);
		r = wr_refused_q;
		reg_wr = 0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask
	// one read; unknown when no valid answer
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge ref_clk);
		reg_rd = 1;
		reg_addr = a;
		@(negedge ref_clk);
		v = reg_rvalid_q ? reg_rdata_q : 8'hxx;
		reg_rd = 0;
		reg_addr = ~a;
	endtask
	// new limit code, gain and compensation kept
	task automatic set_limit(input logic [3:0] c);
		logic [7:0] v;
		logic r;
		rd(8'h08, v);
		wr(8'h08, {v[7:4], c}, r);
	endtask
endmodule // ptc_host_model

// *** ptc_protection_threshold_config.v ***
// ptc_protection_threshold_config.v: protection threshold register bank,
// absolute threshold computation and event classification.
// assumes: register port, run bit, setpoint and event inputs all come from
// logic on ref_clk, so none of them is synchronised here.
`timescale 1ns/1ps
`include "ptc_defs.vh"

module ptc_protection_threshold_config #(
	parameter VW = 16
) (
	input wire ref_clk, // system clock, 200 MHz
	input wire rst_n, // async reset, active low
	input wire reg_wr, // register write strobe
	input wire reg_rd, // register read strobe
	input wire [7:0] reg_addr, // register offset
	input wire [7:0] reg_wdata, // write data
	output reg [7:0] reg_rdata_q, // read data, one cycle after strobe
	output reg reg_rvalid_q, // read data valid pulse
	output reg wr_refused_q, // pulse: threshold write ignored
	input wire pwm_run, // modulator run bit
	input wire [VW-1:0] setpoint, // present output setpoint
	input wire ev_temp_near, // overtemperature near
	input wire ev_out_of_window, // output outside good window
	input wire ev_overcurrent, // overcurrent detected
	input wire ev_overvoltage, // overvoltage detected
	input wire ev_overtemp, // overtemperature detected
	input wire ev_track_fail, // tracking failure
	input wire ev_undervoltage, // undervoltage detected
	output wire [VW-1:0] ov_level_q, // absolute overvoltage level
	output wire [VW-1:0] uv_level_q, // absolute undervoltage level
	output wire [VW-1:0] good_hi_level_q, // absolute upper good limit
	output wire [VW-1:0] good_lo_level_q, // absolute lower good limit
	output reg [7:0] oc_pct_q, // overcurrent limit, percent
	output reg limit_temp_comp_enable_q, // temp compensation of limit
	output reg [2:0] load_line_gain_q, // gain code
	output reg [8:0] load_line_centi_q, // gain, hundredths V/A/ohm
	output reg warning_q, // any warning event
	output reg fault_q, // any fault event
	output reg error_q // any error event
);

	reg [7:0] current_limit_setting_q;
	reg [7:0] current_limit_setting_d;
	reg [5:0] protection_config_two_q;
	reg [5:0] protection_config_two_d;
	reg [7:0] rdata_d;
	reg refused_d;
	reg [7:0] ov_pct;
	reg [7:0] uv_pct;
	reg [7:0] good_hi_pct;
	reg [7:0] good_lo_pct;

	wire good_window_upper_sel;
	wire good_window_lower_sel;
	wire [1:0] overvoltage_level_sel;
	wire [1:0] undervoltage_level_sel;
	wire [3:0] overcurrent_threshold_code;
	wire [2:0] load_line_gain;
	wire limit_temp_comp_enable;
	wire hit_limit;
	wire hit_thresh;

	// threshold register reset value, unimplemented bits dropped
	localparam [7:0] thresh_rst_val =
		`PTC_RST_PROTECTION_CONFIG_TWO & `PTC_THRESH_IMPL_MASK;

	// percent for a base plus code times step
	function [7:0] step_pct;
		input [7:0] base;
		input [7:0] step;
		input [3:0] code;
		begin
			step_pct = base + step * {4'h0, code};
		end
	endfunction

	// gain lookup, hundredths of V/A/ohm
	function [8:0] gain_centi;
		input [2:0] code;
		begin
			case (code)
				3'h0: gain_centi = `PTC_GAIN_C0;
				3'h1: gain_centi = `PTC_GAIN_C1;
				3'h2: gain_centi = `PTC_GAIN_C2;
				3'h3: gain_centi = `PTC_GAIN_C3;
				3'h4: gain_centi = `PTC_GAIN_C4;
				3'h5: gain_centi = `PTC_GAIN_C5;
				3'h6: gain_centi = `PTC_GAIN_C6;
				default: gain_centi = `PTC_GAIN_C7;
			endcase
		end
	endfunction

	// field views of the two registers
	assign good_window_upper_sel = protection_config_two_q[`PTC_GOOD_UPPER_BIT];
	assign good_window_lower_sel = protection_config_two_q[`PTC_GOOD_LOWER_BIT];
	assign overvoltage_level_sel =
		protection_config_two_q[`PTC_OV_MSB:`PTC_OV_LSB];
	assign undervoltage_level_sel =
		protection_config_two_q[`PTC_UV_MSB:`PTC_UV_LSB];
	assign overcurrent_threshold_code =
		current_limit_setting_q[`PTC_OC_MSB:`PTC_OC_LSB];
	assign load_line_gain = current_limit_setting_q[`PTC_GAIN_MSB:`PTC_GAIN_LSB];
	assign limit_temp_comp_enable = current_limit_setting_q[`PTC_TCOMP_BIT];
	assign hit_limit = (reg_addr == `PTC_OFS_CURRENT_LIMIT_SETTING);
	assign hit_thresh = (reg_addr == `PTC_OFS_PROTECTION_CONFIG_TWO);

	// write decode; threshold register locked while running
	always @* begin
		current_limit_setting_d = current_limit_setting_q;
		protection_config_two_d = protection_config_two_q;
		refused_d = 1'b0;
		if (reg_wr && hit_limit) begin
			current_limit_setting_d = reg_wdata;
		end
		if (reg_wr && hit_thresh) begin
			if (pwm_run) begin
				refused_d = 1'b1;
			end else begin
				protection_config_two_d = reg_wdata[5:0];
			end
		end
	end

	// read decode; unmapped offsets read zero
	always @* begin
		rdata_d = 8'h00;
		if (hit_limit) begin
			rdata_d = current_limit_setting_q;
		end else if (hit_thresh) begin
			rdata_d = {2'b00, protection_config_two_q};
		end
	end

	// register storage and bus answers
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			current_limit_setting_q <= `PTC_RST_CURRENT_LIMIT_SETTING;
			protection_config_two_q <= thresh_rst_val[5:0];
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
			wr_refused_q <= 1'b0;
		end else begin
			current_limit_setting_q <= current_limit_setting_d;
			protection_config_two_q <= protection_config_two_d;
			reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
			reg_rvalid_q <= reg_rd;
			wr_refused_q <= refused_d;
		end
	end

	// percent selection for the voltage thresholds
	always @* begin
		good_hi_pct = good_window_upper_sel ? `PTC_PCT_GOOD_UP_LOW :
			`PTC_PCT_GOOD_UP_HIGH;
		good_lo_pct = good_window_lower_sel ? `PTC_PCT_GOOD_LO_HIGH :
			`PTC_PCT_GOOD_LO_LOW;
		ov_pct = step_pct(`PTC_PCT_OV_BASE, `PTC_PCT_OV_STEP,
			{2'b00, overvoltage_level_sel});
		uv_pct = step_pct(`PTC_PCT_UV_BASE, `PTC_PCT_UV_STEP,
			{2'b00, undervoltage_level_sel});
	end

	// absolute levels track the live setpoint every cycle
	ptc_scale #(.VW(VW)) u_scale_ov (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setpoint(setpoint),
		.pct(ov_pct),
		.level_q(ov_level_q)
	);

	ptc_scale #(.VW(VW)) u_scale_uv (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setpoint(setpoint),
		.pct(uv_pct),
		.level_q(uv_level_q)
	);

	ptc_scale #(.VW(VW)) u_scale_good_hi (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setpoint(setpoint),
		.pct(good_hi_pct),
		.level_q(good_hi_level_q)
	);

	ptc_scale #(.VW(VW)) u_scale_good_lo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.setpoint(setpoint),
		.pct(good_lo_pct),
		.level_q(good_lo_level_q)
	);

	// current limit, gain and classification outputs
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_pct_q <= 8'h00;
			limit_temp_comp_enable_q <= 1'b0;
			load_line_gain_q <= 3'h0;
			load_line_centi_q <= 9'h000;
			warning_q <= 1'b0;
			fault_q <= 1'b0;
			error_q <= 1'b0;
		end else begin
			// top step and the codes above it give the top percentage
			if (overcurrent_threshold_code >= `PTC_OC_CODE_MAX) begin
				oc_pct_q <= `PTC_PCT_OC_TOP;
			end else begin
				oc_pct_q <= step_pct(`PTC_PCT_OC_BASE, `PTC_PCT_OC_STEP,
					overcurrent_threshold_code);
			end
			limit_temp_comp_enable_q <= limit_temp_comp_enable;
			load_line_gain_q <= load_line_gain;
			load_line_centi_q <= gain_centi(load_line_gain);
			warning_q <= ev_temp_near | ev_out_of_window;
			fault_q <= ev_overcurrent | ev_overvoltage | ev_overtemp |
				ev_track_fail;
			error_q <= ev_undervoltage;
		end
	end

endmodule // ptc_protection_threshold_config

// *** ptc_scale.v ***
// ptc_scale.v: scales a setpoint by a percentage, registered result.
// assumes: setpoint and percentage come from logic on ref_clk.
`timescale 1ns/1ps
`include "ptc_defs.vh"

module ptc_scale #(
	parameter VW = 16
) (
	input wire ref_clk, // system clock
	input wire rst_n, // async reset, active low
	input wire [VW-1:0] setpoint, // present output setpoint
	input wire [7:0] pct, // percentage of setpoint
	output reg [VW-1:0] level_q // absolute threshold
);

	wire [VW+7:0] prod;
	wire [VW+7:0] quot;

	// product then divide by one hundred, recomputed every cycle
	assign prod = setpoint * pct;
	assign quot = prod / `PTC_PCT_DIVISOR;

	// result clamps to the setpoint width
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= {VW{1'b0}};
		end else if (|quot[VW+7:VW]) begin
			level_q <= {VW{1'b1}};
		end else begin
			level_q <= quot[VW-1:0];
		end
	end

endmodule // ptc_scale

// *** test_protection_threshold_config.sv ***
// test_protection_threshold_config.sv: self-checking bench.
// assumes: host model owns the register port.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	miscompares++; $display("wrong value %0t %h %h", $time, a, e); end end
module test_protection_threshold_config;
	logic ref_clk = 0, rst_n = 0, reg_wr, reg_rd, pwm_run, rf;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, oc_pct_q, d, e;
	logic reg_rvalid_q, wr_refused_q, limit_temp_comp_enable_q;
	logic warning_q, fault_q, error_q;
	logic [15:0] setpoint = 0, ov_level_q, uv_level_q;
	logic [15:0] good_hi_level_q, good_lo_level_q;
	logic [6:0] ev = 0;
	logic [2:0] load_line_gain_q;
	logic [8:0] load_line_centi_q;
	int miscompares = 0, samples_checked = 0, cyc = 0;
	int cent[8] = '{0, 39, 78, 118, 157, 196, 235, 275};
	always #2.5 ref_clk = ~ref_clk;
	ptc_protection_threshold_config #(.VW(16))
		ptc_protection_threshold_config_inst (.ref_clk, .rst_n, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_rvalid_q,
		.wr_refused_q, .pwm_run, .setpoint, .ev_temp_near(ev[0]),
		.ev_out_of_window(ev[1]), .ev_overcurrent(ev[2]),
		.ev_overvoltage(ev[3]), .ev_overtemp(ev[4]), .ev_track_fail(ev[5]),
		.ev_undervoltage(ev[6]), .ov_level_q, .uv_level_q, .good_hi_level_q,
		.good_lo_level_q, .oc_pct_q, .limit_temp_comp_enable_q,
		.load_line_gain_q, .load_line_centi_q, .warning_q, .fault_q, .error_q);
	ptc_host_model ptc_host_model_inst (.ref_clk, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .pwm_run, .reg_rdata_q, .reg_rvalid_q,
		.wr_refused_q);
	// floor of setpoint share, saturating
	function automatic logic [15:0] lvl(input logic [15:0] s, input int p);
		int v;
		v = s * p / 100;
		return v > 65535 ? 16'hffff : v[15:0];
	endfunction
	// new setpoint, then compare the four levels; ov 0 skips
	task automatic chk_lvl(input int ov, uv, hi, lo);
		setpoint = 16'($urandom);
		repeat (4) @(negedge ref_clk);
		if (ov) `CHK(ov_level_q, lvl(setpoint, ov))
		`CHK(uv_level_q, lvl(setpoint, uv))
		`CHK(good_hi_level_q, lvl(setpoint, hi))
		`CHK(good_lo_level_q, lvl(setpoint, lo))
	endtask
	task tally_and_finish;
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk) if (++cyc == 20000) begin
		miscompares++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hf341));
		repeat (3) @(negedge ref_clk);
		rst_n = 1;
		repeat (3) @(negedge ref_clk);
		`CHK(oc_pct_q, 8'd140)
		`CHK(limit_temp_comp_enable_q, 1'b1)
		ptc_host_model_inst.rd(8'h08, d);
		`CHK(d, 8'h1b)
		ptc_host_model_inst.rd(8'h09, d);
		`CHK(d, 8'h08)
		chk_lvl(130, 75, 110, 90);
		ptc_host_model_inst.rd(8'h2a, d);
		`CHK(d, 8'h00)
		// every threshold code, unused bits set at random
		for (int i = 0; i < 64; i++) begin
			d = 8'($urandom);
			d[5:0] = 6'(i);
			ptc_host_model_inst.wr(8'h09, d, rf);
			`CHK(rf, 1'b0)
			ptc_host_model_inst.rd(8'h09, e);
			`CHK(e, {2'h0, d[5:0]})
			chk_lvl(d[3:2] == 3 ? 0 : 110 + 10 * d[3:2], 75 + 5 * d[1:0],
				d[5] ? 105 : 110, d[4] ? 95 : 90);
		end
		// locked while running
		ptc_host_model_inst.pwm_run = 1;
		ptc_host_model_inst.wr(8'h09, 8'h00, rf);
		`CHK(rf, 1'b1)
		ptc_host_model_inst.rd(8'h09, e);
		`CHK(e, 8'h3f)
		ptc_host_model_inst.pwm_run = 0;
		// every limit code with random gain and compensation
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			d[3:0] = 4'(i);
			ptc_host_model_inst.wr(8'h08, d, rf);
			ptc_host_model_inst.set_limit(4'(15 - i));
			ptc_host_model_inst.rd(8'h08, e);
			`CHK(e, {d[7:4], 4'(15 - i)})
			repeat (2) @(negedge ref_clk);
			`CHK(oc_pct_q, 8'(i <= 4 ? 140 : 37 + 10 * (15 - i)))
			`CHK(limit_temp_comp_enable_q, d[4])
			`CHK(load_line_gain_q, d[7:5])
			`CHK(load_line_centi_q, 9'(cent[d[7:5]]))
		end
		// random events, classes one cycle later
		repeat (200) begin
			ev = 7'($urandom);
			@(negedge ref_clk);
			`CHK(warning_q, |ev[1:0])
			`CHK(fault_q, |ev[5:2])
			`CHK(error_q, ev[6])
		end
		tally_and_finish;
	end
endmodule // test_protection_threshold_config
bind ptc_protection_threshold_config ptc_assertions ptc_assertions_inst (
	.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_rdata_q,
	.reg_rvalid_q, .wr_refused_q, .pwm_run, .ev_temp_near, .ev_out_of_window,
	.ev_overcurrent, .ev_overvoltage, .ev_overtemp, .ev_track_fail,
	.ev_undervoltage, .warning_q, .fault_q, .error_q, .load_line_gain_q,
	.load_line_centi_q);
